// ---- shared/seq_pkg.sv ----
/*
  seq_pkg: constants, address map, encodings and carrier structs of the
  program sequencer.
  assumes: included ahead of every file that uses the sequencer.
*/
`default_nettype none
package seq_pkg;
    // -------------------------------------------------------------
    // widths and sizes
    // -------------------------------------------------------------
    localparam int PC_W        = 15;
    localparam int LOW_W       = 13;
    localparam int WORD_W      = 16;
    localparam int STACK_DEPTH = 8;
    localparam int GP_WORDS    = 224;
    localparam int BANK_LO     = 5;
    localparam int BANK_HI     = 6;
    localparam int PH_LAST     = 3;
    localparam logic [3:0] STACK_FULL  = 4'h8;
    localparam logic [3:0] PHASE_FIRST = 4'h1;
    // -------------------------------------------------------------
    // data space map
    // -------------------------------------------------------------
    localparam logic [7:0] ADDR_IND_A    = 8'h00;
    localparam logic [7:0] ADDR_PTR_A    = 8'h01;
    localparam logic [7:0] ADDR_IND_B    = 8'h02;
    localparam logic [7:0] ADDR_PTR_B    = 8'h03;
    localparam logic [7:0] ADDR_BANK     = 8'h04;
    localparam logic [7:0] ADDR_PCL      = 8'h06;
    localparam logic [7:0] ADDR_TABLE_POINTER_LOW     = 8'h07;
    localparam logic [7:0] ADDR_TABLE_RESULT_HIGH     = 8'h08;
    localparam logic [7:0] ADDR_TABLE_PAGE_SELECT     = 8'h1F;
    localparam logic [7:0] ADDR_GP_FIRST = 8'h20;
    localparam logic [7:0] RESET_BYTE    = 8'h00;
    // -------------------------------------------------------------
    // program addresses
    // -------------------------------------------------------------
    localparam logic [14:0] VEC_RESET = 15'h0000;
    localparam logic [14:0] VEC_EXT   = 15'h0004;
    localparam logic [14:0] VEC_T0    = 15'h0008;
    localparam logic [14:0] VEC_T1    = 15'h000C;
    localparam logic [6:0]  LAST_PAGE = 7'h5F;
    // -------------------------------------------------------------
    // timing: start-up in system clock periods, clk is that clock
    // -------------------------------------------------------------
    localparam int STARTUP_TSYS   = 1024;
    localparam int CLK_PER_TSYS   = 1;
    localparam int STARTUP_CYCLES = STARTUP_TSYS * CLK_PER_TSYS;
    localparam int STARTUP_W      = 11;
    localparam logic [10:0] STARTUP_LAST = 11'(STARTUP_CYCLES - 1);
    // -------------------------------------------------------------
    // types
    // -------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_NONE, OP_JUMP, OP_CALL, OP_SKIP, OP_RETURN_PLAIN,
        OP_RETURN_FROM_IRQ, OP_TABLE_READ_PAGED, OP_TABLE_READ_LAST_PAGE
    } seq_op_t;
    typedef enum logic [1:0] {RUN_STARTUP, RUN_ACTIVE, RUN_HALTED}
        run_state_t;
    typedef struct packed {
        seq_op_t     op;
        logic [12:0] target;
        logic [7:0]  tableDest;
    } seq_ctrl_t;
    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mem_req_t;
endpackage
`default_nettype wire

// ---- rtl/program_sequencer_stack.sv ----
/*
  program_sequencer_stack: four-phase timing, fetch/execute pipeline,
  program counter, return stack, table reads and the sequencer's own
  data space (pointers, bank, table registers, bytes 20H..FFH).
  assumes: the program rom answers romAddr within one clock; ctrl and
  mem come from the execution unit on clk; irqPending lines are flags
  already gated by their enables and master enable.
*/
// Contract
// RULE_01 - clock splits into four phases; one instruction cycle is four clocks
// RULE_02 - fetch overlaps execute; a counter-changing instruction takes two cycles
// RULE_03 - counter advances by one after every program word fetch
// RULE_04 - taken skip discards the prefetched word and inserts a dummy cycle
// RULE_05 - taken skip adds two to low thirteen bits, bank bits kept
// RULE_06 - writing counter low byte loads low eight bits: short jump
// RULE_07 - chip reset clears the program counter to zero
// RULE_08 - acknowledged interrupt loads 004H, 008H or 00CH by source
// RULE_09 - three banks of 8192 words; jumps take bank bits 5 and 6; code does not limit these bits and uses all four values as banks
// RULE_10 - call or interrupt acknowledge pushes only the program counter
// RULE_11 - either return pops the stack into the whole counter
// RULE_12 - stack has eight levels, hidden from software with its index
// RULE_13 - full stack holds off interrupt acknowledge until a return
// RULE_14 - call on full stack overwrites oldest entry, keeps newest eight
// RULE_15 - reset sets the stack index to empty
// RULE_16 - paged table read: page register plus pointer; low to [m], high kept
// RULE_17 - last-page table read uses fixed upper bits 1011111
// RULE_18 - table result register is read only; writes ignored
// RULE_19 - every table read takes two instruction cycles
// RULE_20 - unimplemented addresses below 20H read as zero
// RULE_21 - general purpose bytes 20H..FFH, direct and through both pointers
// RULE_22 - hold execution 1024 clocks after reset or wake from halt
// RULE_23 - simultaneous interrupts served external, timer zero, timer one
`timescale 1ns/1ps
`default_nettype none
module program_sequencer_stack (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rst_n,
    // program rom
    output logic [14:0]              romAddr,
    input  wire logic [15:0]         romData,
    // execution unit
    output logic [15:0]              instrWord,
    output logic                     instrValid,
    output logic [3:0]               phase,
    output logic                     running,
    input  wire seq_pkg::seq_ctrl_t  ctrl,
    input  wire logic                haltRequest,
    // data space
    input  wire seq_pkg::mem_req_t   mem,
    output logic [7:0]               memRdata,
    // interrupts and wake
    input  wire logic [2:0]          irqPending,
    output logic [2:0]               irqAck,
    output logic                     irqReturn,
    input  wire logic                wakePin
);
    import seq_pkg::*;

    // -------------------------------------------------------------
    // functions
    // -------------------------------------------------------------
    // indirect slots map through a pointer; pointing back at a slot
    // gives an invalid access (reads zero, writes dropped)
    function automatic logic [8:0] resolveSlot(
        input logic [7:0] a,
        input logic [7:0] pa,
        input logic [7:0] pb);
        logic [7:0] t;
        logic       ind;
        t   = (a == ADDR_IND_A) ? pa : ((a == ADDR_IND_B) ? pb : a);
        ind = (a == ADDR_IND_A) || (a == ADDR_IND_B);
        resolveSlot = {!(ind && (t == ADDR_IND_A || t == ADDR_IND_B)), t};
    endfunction

    function automatic logic [2:0] pickIrq(input logic [2:0] p);
        pickIrq = p[0] ? 3'h1 : (p[1] ? 3'h2 : (p[2] ? 3'h4 : 3'h0));
    endfunction

    // -------------------------------------------------------------
    // state
    // -------------------------------------------------------------
    run_state_t         runState;
    run_state_t         next_runState;
    logic [STARTUP_W-1:0] startupCount;
    logic               wakeMeta;
    logic               wakeSync;
    logic [14:0]        pc;
    logic [15:0]        holdWord;
    logic               tableCycle;
    logic [7:0]         tableDest;
    logic [14:0]        stackMem [STACK_DEPTH];
    logic [2:0]         topPtr;
    logic [3:0]         depth;
    logic [7:0]         ptrA;
    logic [7:0]         ptrB;
    logic [7:0]         bankSel;
    logic [7:0]         table_pointer_low;
    logic [7:0]         table_page_select;
    logic [7:0]         table_result_high;
    logic [7:0]         pclValue;
    logic               pclPending;
    logic [7:0]         gpRam [GP_WORDS];
    logic [7:0]         readValue;
    logic               readHit;

    // -------------------------------------------------------------
    // wake synchroniser and run control
    // -------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wakeMeta <= 1'b0;
            wakeSync <= 1'b0;
        end else begin
            wakeMeta <= wakePin;
            wakeSync <= wakeMeta;
        end
    end

    always_comb begin
        next_runState = runState;
        case (runState)
            RUN_STARTUP: begin
                if (startupCount == STARTUP_LAST)
                    next_runState = RUN_ACTIVE;  // [RULE_22]
            end
            RUN_ACTIVE: begin
                if (phase[PH_LAST] && haltRequest)
                    next_runState = RUN_HALTED;
            end
            RUN_HALTED: begin
                if (wakeSync)
                    next_runState = RUN_STARTUP;  // [RULE_22]
            end
            default: next_runState = RUN_STARTUP;
        endcase
    end

    wire leaveStartup = (runState == RUN_STARTUP) &&
                        (next_runState == RUN_ACTIVE);
    // restart the phases so the first cycle after start-up is whole
    wire [3:0] next_phase = leaveStartup ? PHASE_FIRST
                                         : {phase[2:0], phase[3]};

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            runState     <= RUN_STARTUP;  // [RULE_22]
            startupCount <= '0;
            running      <= 1'b0;
            phase        <= PHASE_FIRST;
        end else begin
            runState     <= next_runState;
            startupCount <= (runState == RUN_STARTUP) ?
                            startupCount + 11'h001 : '0;
            running      <= (next_runState == RUN_ACTIVE);
            phase        <= next_phase;  // [RULE_01]
        end
    end

    // -------------------------------------------------------------
    // decode of the executing instruction
    // -------------------------------------------------------------
    wire     cycleEnd = phase[PH_LAST] && (runState == RUN_ACTIVE);
    seq_op_t execOp;
    assign   execOp = instrValid ? ctrl.op : OP_NONE;
    wire     isRet  = (execOp == OP_RETURN_PLAIN) ||
                      (execOp == OP_RETURN_FROM_IRQ);
    wire     isTab  = (execOp == OP_TABLE_READ_PAGED) ||
                      (execOp == OP_TABLE_READ_LAST_PAGE);
    wire     isBranch = (execOp == OP_JUMP) || (execOp == OP_CALL);
    wire     stackFull = (depth == STACK_FULL);
    wire     storeLow  = cycleEnd && tableCycle;

    // write port shared by the bus and the table low-byte store
    wire       wrEn   = mem.write || storeLow;
    wire [7:0] wrAddr = storeLow ? tableDest : mem.addr;
    wire [7:0] wrData = storeLow ? romData[7:0] : mem.wdata;
    wire [8:0] wrSlot = resolveSlot(wrAddr, ptrA, ptrB);
    wire [8:0] rdSlot = resolveSlot(mem.addr, ptrA, ptrB);
    wire       pclHit = wrEn && (wrSlot == {1'b1, ADDR_PCL});
    wire       loadPcl = pclHit || pclPending;

    // a pending interrupt only enters at a plain instruction boundary
    wire [2:0] irqPick = pickIrq(irqPending);  // [RULE_23]
    // dummy cycles are excluded so a vector's first word always executes
    wire irqTake = cycleEnd && !tableCycle && instrValid &&
                   (execOp == OP_NONE) &&
                   !loadPcl && !stackFull && (irqPending != 3'h0);  // [RULE_13]
    wire [14:0] irqVector = irqPick[0] ? VEC_EXT :
                            (irqPick[1] ? VEC_T0 : VEC_T1);  // [RULE_08]

    // -------------------------------------------------------------
    // program counter targets
    // -------------------------------------------------------------
    // pc holds the word being fetched, i.e. one past the executing
    // instruction, so +1 here lands two past the skipping instruction
    wire [14:0] pcPlus = pc + 15'h0001;  // [RULE_03]
    wire [14:0] skipTarget = {pc[14:13], pc[12:0] + 13'h0001};  // [RULE_05]
    wire [14:0] bankedTarget = {bankSel[BANK_HI:BANK_LO], ctrl.target};  // [RULE_09]
    wire [7:0]  pclByte   = pclHit ? wrData : pclValue;
    wire [14:0] pclTarget = {pc[14:8], pclByte};  // [RULE_06]
    wire [14:0] popAddr   = stackMem[topPtr];
    wire [14:0] tableAddr = (execOp == OP_TABLE_READ_PAGED) ?
                            {table_page_select[6:0], table_pointer_low} :  // [RULE_16]
                            {LAST_PAGE, table_pointer_low};  // [RULE_17]

    wire takeTransfer = cycleEnd && !tableCycle &&
                        (isBranch || isRet || (execOp == OP_SKIP) ||
                         loadPcl || irqTake);
    wire [14:0] transferTarget =
        isBranch ? bankedTarget :
        ((execOp == OP_SKIP) ? skipTarget :
        (isRet ? popAddr :  // [RULE_11]
        (loadPcl ? pclTarget : irqVector)));
    wire startTable = cycleEnd && !tableCycle && isTab && !loadPcl;

    wire [14:0] next_pc = tableCycle ? pc :
                          (takeTransfer ? transferTarget : pcPlus);
    wire [14:0] next_romAddr = tableCycle ? pc :
                               (takeTransfer ? transferTarget :
                               (startTable ? tableAddr : pcPlus));
    wire [15:0] next_instrWord  = tableCycle ? holdWord : romData;
    // a transfer or table read leaves a dummy cycle behind it
    wire        next_instrValid = tableCycle ||
                                  !(takeTransfer || startTable);  // [RULE_02] [RULE_04]

    // -------------------------------------------------------------
    // fetch pipeline
    // -------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pc         <= VEC_RESET;  // [RULE_07]
            romAddr    <= VEC_RESET;
            instrWord  <= 16'h0000;
            instrValid <= 1'b0;
            tableCycle <= 1'b0;
        end else if (cycleEnd) begin
            pc         <= next_pc;
            romAddr    <= next_romAddr;
            instrWord  <= next_instrWord;
            instrValid <= next_instrValid;
            tableCycle <= startTable;  // [RULE_19]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            holdWord  <= 16'h0000;
            tableDest <= RESET_BYTE;
            table_result_high      <= RESET_BYTE;
        end else begin
            if (startTable) begin
                holdWord  <= romData;
                tableDest <= ctrl.tableDest;
            end
            if (storeLow)
                table_result_high <= romData[15:8];  // [RULE_16] [RULE_18]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irqAck    <= 3'h0;
            irqReturn <= 1'b0;
        end else begin
            irqAck    <= irqTake ? irqPick : 3'h0;
            irqReturn <= takeTransfer && (execOp == OP_RETURN_FROM_IRQ);
        end
    end

    // -------------------------------------------------------------
    // return stack: circular, so a push when full drops the oldest
    // -------------------------------------------------------------
    wire push = cycleEnd && !tableCycle &&
                ((execOp == OP_CALL) || irqTake);  // [RULE_10]
    wire pop  = cycleEnd && !tableCycle && isRet;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            topPtr <= 3'h0;
            depth  <= 4'h0;  // [RULE_15]
        end else if (push) begin
            topPtr <= topPtr + 3'h1;
            depth  <= stackFull ? depth : depth + 4'h1;  // [RULE_14]
        end else if (pop && depth != 4'h0) begin
            topPtr <= topPtr - 3'h1;
            depth  <= depth - 4'h1;
        end
    end

    // no bus path reaches the entries or the index
    always_ff @(posedge clk) begin
        if (push)
            stackMem[topPtr + 3'h1] <= pc;  // [RULE_12]
    end

    // -------------------------------------------------------------
    // data space registers and general purpose bytes
    // -------------------------------------------------------------
    wire [7:0] wrIdx = wrSlot[7:0] - ADDR_GP_FIRST;
    wire [7:0] rdIdx = rdSlot[7:0] - ADDR_GP_FIRST;
    wire       wrOk  = wrEn && wrSlot[8];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ptrA    <= RESET_BYTE;
            ptrB    <= RESET_BYTE;
            bankSel <= RESET_BYTE;
            table_pointer_low    <= RESET_BYTE;
            table_page_select    <= RESET_BYTE;
        end else if (wrOk) begin
            case (wrSlot[7:0])
                ADDR_PTR_A: ptrA    <= wrData;
                ADDR_PTR_B: ptrB    <= wrData;
                ADDR_BANK:  bankSel <= wrData;
                ADDR_TABLE_POINTER_LOW:  table_pointer_low    <= wrData;
                ADDR_TABLE_PAGE_SELECT:  table_page_select    <= wrData;
                default:    ;  // table result is not writable [RULE_18]
            endcase
        end
    end

    // a bus write to the low byte lands at the end of its cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pclValue   <= RESET_BYTE;
            pclPending <= 1'b0;
        end else begin
            if (pclHit)
                pclValue <= wrData;
            pclPending <= cycleEnd ? 1'b0 : (pclHit || pclPending);  // [RULE_06]
        end
    end

    // data memory has no reset; its content is undefined at start
    always_ff @(posedge clk) begin
        if (wrOk && wrSlot[7:0] >= ADDR_GP_FIRST)
            gpRam[wrIdx] <= wrData;  // [RULE_21]
    end

    always_comb begin
        readValue = RESET_BYTE;
        readHit   = 1'b0;
        if (rdSlot[8]) begin
            readHit = 1'b1;
            if (rdSlot[7:0] >= ADDR_GP_FIRST) begin
                readValue = gpRam[rdIdx];  // [RULE_21]
            end else begin
                case (rdSlot[7:0])
                    ADDR_PTR_A: readValue = ptrA;
                    ADDR_PTR_B: readValue = ptrB;
                    ADDR_BANK:  readValue = bankSel;
                    ADDR_PCL:   readValue = pc[7:0];
                    ADDR_TABLE_POINTER_LOW:  readValue = table_pointer_low;
                    ADDR_TABLE_RESULT_HIGH:  readValue = table_result_high;
                    ADDR_TABLE_PAGE_SELECT:  readValue = table_page_select;
                    default:    readHit   = 1'b0;  // [RULE_20]
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            memRdata <= RESET_BYTE;
        else if (mem.read)
            memRdata <= readValue;
    end

    // -------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic [STARTUP_W-1:0] stayCount;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            stayCount <= '0;
        else
            stayCount <= (runState == RUN_STARTUP) ? stayCount + 11'h001
                                                   : '0;
    end

    sequence tableHold;
        tableCycle [*4];
    endsequence
    sequence tableResume;
        !tableCycle && instrValid;
    endsequence

    a_phase_four: assert property (  // [RULE_01]
        (phase[0] && runState == RUN_ACTIVE) |=>
        phase[1] ##1 phase[2] ##1 phase[3] ##1 phase[0])
        else $error("phase rotation is not four clocks");
    a_pc_step: assert property (  // [RULE_03]
        (cycleEnd && !takeTransfer && !tableCycle) |=>
        pc == $past(pc) + 15'h0001)
        else $error("pc did not advance by one");
    a_transfer_dummy: assert property (  // [RULE_02]
        takeTransfer |=> !instrValid ##4 instrValid)
        else $error("transfer did not take two cycles");
    a_skip_bank: assert property (  // [RULE_05]
        (takeTransfer && execOp == OP_SKIP) |=>
        pc[14:13] == $past(pc[14:13]) &&
        pc[12:0] == $past(pc[12:0]) + 13'h0001)
        else $error("skip target wrong or left the bank");
    a_vector_ext: assert property (  // [RULE_08]
        irqAck[0] |-> pc == VEC_EXT && !instrValid)
        else $error("external vector not loaded");
    a_full_blocks: assert property (  // [RULE_13]
        (stackFull && cycleEnd) |=> irqAck == 3'h0)
        else $error("interrupt acknowledged with full stack");
    a_push_depth: assert property (  // [RULE_14]
        push |=> depth == (($past(depth) == STACK_FULL) ?
                           STACK_FULL : $past(depth) + 4'h1))
        else $error("stack depth wrong after push");
    a_return_pop: assert property (  // [RULE_11]
        (takeTransfer && isRet) |=> pc == $past(popAddr))
        else $error("return did not reload the popped address");
    a_table_two: assert property (  // [RULE_19]
        startTable |=> tableHold ##1 tableResume)
        else $error("table read not two cycles");
    a_table_result_high_hold: assert property (  // [RULE_18]
        !storeLow |=> $stable(table_result_high))
        else $error("table result changed without a table read");
    a_unmapped_zero: assert property (  // [RULE_20]
        (mem.read && !readHit) |=> memRdata == 8'h00)
        else $error("unimplemented address read nonzero");
    a_startup_len: assert property (  // [RULE_22]
        $rose(running) |-> stayCount == 11'd1024)
        else $error("start-up hold not 1024 clocks");
endmodule // program_sequencer_stack
`default_nettype wire

// ---- verification/rom_irq_model.sv ----
/*
  rom_irq_model: program rom whose word is {1, address}, and three
  interrupt request sources.
  assumes: one clock, asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module rom_irq_model (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // program rom
    input  wire logic [14:0] romAddr,
    output logic [15:0]      romData,
    // interrupt sources
    input  wire logic [2:0]  irqRaise,
    input  wire logic [2:0]  irqAck,
    output logic [2:0]       irqPending
);
    // each word names its own address, so a wrong fetch shows at once
    assign romData = {1'b1, romAddr};
    // a flag waits, however long, for its own acknowledge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            irqPending <= 3'h0;
        else
            irqPending <= (irqPending | irqRaise) & ~irqAck;
    end
endmodule // rom_irq_model
`default_nettype wire

// ---- verification/testbench.sv ----
/*
  testbench: start-up, transfers, stack, table reads, data space, irqs.
  assumes: the rom and interrupt model stands beside the sequencer.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin numChecks++; if ((a) !== (e)) begin errTotal++; \
    $display("Error at %0t got %h exp %h", $time, a, e); end end
module testbench;
    import seq_pkg::*;
    logic        clk, rst_n, haltRequest, wakePin, irqReturn;
    logic        instrValid, running;
    logic [14:0] romAddr, p;
    logic [15:0] romData, instrWord;
    logic [3:0]  phase;
    logic [7:0]  memRdata;
    logic [2:0]  irqPending, irqAck, irqRaise;
    seq_ctrl_t   ctrl;
    mem_req_t    mem;
    int          errTotal = 0;
    int          numChecks = 0;
    int          n;
    program_sequencer_stack u_program_sequencer_stack (.clk, .rst_n,
        .romAddr, .romData, .instrWord, .instrValid, .phase, .running,
        .ctrl, .haltRequest, .mem, .memRdata, .irqPending, .irqAck,
        .irqReturn, .wakePin);
    rom_irq_model u_rom_irq_model (.clk, .rst_n, .romAddr, .romData,
        .irqRaise, .irqAck, .irqPending);
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    // returns just after the next cycle-end edge
    task automatic endcyc();
        for (int i = 0; i < 8 && phase[3] !== 1'b1; i++) tick();
        tick();
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        mem = '{1'b1, 1'b0, a, d};
        tick();
        mem = '0;
        tick();
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        mem = '{1'b0, 1'b1, a, 8'h00};
        tick();
        mem = '0;
        tick();
        `CHK(memRdata, e)
    endtask
    // ctrl is ignored in dummy cycles, so wait for a real one first
    task automatic issue(input seq_op_t op, input logic [12:0] t,
                         input logic [7:0] d);
        for (int i = 0; i < 4 && instrValid !== 1'b1; i++) endcyc();
        p = romAddr;
        ctrl = '{op, t, d};
        endcyc();
        ctrl = '{OP_NONE, 13'h0000, 8'h00};
    endtask
    task automatic t_start();
        n = 0;
        while (running !== 1'b1 && n < 1100) begin
            tick();
            n++;
        end
        `CHK(n, 1024)
        `CHK(romAddr, 15'h0000)
        endcyc();
        `CHK(romAddr, 15'h0001)
        `CHK(instrWord, 16'h8000)
        $display("test start done");
    endtask
    task automatic t_flow();
        wr(ADDR_BANK, 8'h20);
        issue(OP_JUMP, 13'h1FFE, 8'h00);
        `CHK(romAddr, 15'h3FFE)
        `CHK(instrValid, 1'b0)
        endcyc();
        `CHK(instrWord, 16'hBFFE)
        issue(OP_SKIP, 13'h0000, 8'h00);
        `CHK(romAddr, 15'h2000)
        `CHK(instrValid, 1'b0)
        endcyc();
        wr(ADDR_PCL, 8'h55);
        endcyc();
        `CHK(romAddr, 15'h2055)
        $display("test flow done");
    endtask
    task automatic t_stack();
        logic [14:0] ret [9];
        for (int i = 0; i < 9; i++) begin
            issue(OP_CALL, 13'(i * 16), 8'h00);
            ret[i] = p;
            `CHK(romAddr, {2'b01, 13'(i * 16)})
        end
        for (int i = 8; i > 0; i--) begin
            issue(OP_RETURN_PLAIN, 13'h0000, 8'h00);
            `CHK(romAddr, ret[i])
        end
        $display("test stack done");
    endtask
    task automatic t_table();
        wr(ADDR_TABLE_PAGE_SELECT, 8'h12);
        wr(ADDR_TABLE_POINTER_LOW, 8'h34);
        issue(OP_TABLE_READ_PAGED, 13'h0000, 8'h40);
        `CHK(romAddr, 15'h1234)
        endcyc();
        `CHK(instrValid, 1'b1)
        rd(ADDR_TABLE_RESULT_HIGH, 8'h92);
        rd(8'h40, 8'h34);
        issue(OP_TABLE_READ_LAST_PAGE, 13'h0000, 8'h41);
        `CHK(romAddr, 15'h5F34)
        endcyc();
        wr(ADDR_TABLE_RESULT_HIGH, 8'h00);
        rd(ADDR_TABLE_RESULT_HIGH, 8'hDF);
        wr(ADDR_PTR_B, 8'hFF);
        wr(ADDR_IND_B, 8'h5A);
        rd(8'hFF, 8'h5A);
        rd(8'h05, 8'h00);
        $display("test table done");
    endtask
    task automatic t_irq();
        irqRaise = 3'b111;
        tick();
        irqRaise = 3'b000;
        for (int s = 0; s < 3; s++) begin
            n = 0;
            while (irqAck === 3'b000 && n < 40) begin
                tick();
                n++;
            end
            `CHK(irqAck, 3'(1 << s))
            `CHK(romAddr, 15'(4 * s + 4))
            issue(OP_RETURN_FROM_IRQ, 13'h0000, 8'h00);
            `CHK(irqReturn, 1'b1)
        end
        $display("test irq done");
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", numChecks, errTotal);
        if (errTotal == 0 && numChecks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        rst_n = 1'b0;
        haltRequest = 1'b0;
        wakePin = 1'b0;
        irqRaise = 3'h0;
        ctrl = '0;
        mem = '0;
        repeat (4) @(posedge clk);
        #1 rst_n = 1'b1;
        t_start();
        t_flow();
        t_stack();
        t_table();
        t_irq();
        wrap_up();
    end
    // start-up plus every test stays far below this span
    initial begin
        #(5000 * 50);
        errTotal++;
        wrap_up();
    end
endmodule // testbench
`default_nettype wire
